// file: include/lpddr_ctl_map.svh
// Timing counts and field positions for the precharge, refresh and power block
`ifndef LPDDR_CTL_MAP_SVH
`define LPDDR_CTL_MAP_SVH
`define CLK_PERIOD_NS 4
`define NUM_BANKS 4
`define PRECHARGE_PERIOD_NS 18
`define PRECHARGE_PERIOD_CYC ((`PRECHARGE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_RECOVERY_NS 15
`define WRITE_RECOVERY_CYC ((`WRITE_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_CYCLE_NS 110
`define REFRESH_CYCLE_CYC ((`REFRESH_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELF_REFRESH_EXIT_NS 120
`define SELF_REFRESH_EXIT_CYC ((`SELF_REFRESH_EXIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWER_DOWN_EXIT_CYC 2
`define BURST_LEN 4
`define SELF_REFRESH_TIMER_CYC 1950
`define PRECHARGE_SELECT_POS 10
`endif

// file: include/lpddr_ctl_pkg.sv
// Types for the precharge, refresh and power block
package lpddr_ctl_pkg;
  typedef enum logic [1:0] {BANK_IDLE, BANK_ACTIVE, BANK_PRECHARGING} bank_state_t;
  typedef enum logic [2:0] {
    PWR_NORMAL, PWR_PRECHARGE_DOWN, PWR_ACTIVE_DOWN, PWR_SELF_REFRESH, PWR_DEEP_DOWN, PWR_EXIT
  } power_state_t;
  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
    CMD_REFRESH, CMD_BURST_TERMINATE, CMD_MODE_SET
  } command_t;
  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_enable_n;
    logic [1:0] bank_select;
    logic [12:0] address;
  } command_pins_t;
  typedef struct packed {
    logic data_valid;
    logic data_mask;
    logic [15:0] data;
  } write_beat_t;
  typedef struct packed {
    logic array_write;
    logic [1:0] bank;
    logic [15:0] data;
  } array_write_t;
endpackage : lpddr_ctl_pkg

// file: logic/lpddr_ctl.sv
// Precharge, refresh and power state logic of a low power DDR device
`include "lpddr_ctl_map.svh"
module lpddr_ctl (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clock_enable,
  input wire lpddr_ctl_pkg::command_pins_t cmd_pins,
  input wire lpddr_ctl_pkg::write_beat_t write_beat,
  output lpddr_ctl_pkg::array_write_t array_write,
  output logic [12:0] refresh_row,
  output logic refresh_strobe,
  output logic [`NUM_BANKS-1:0] bank_open,
  output logic [`NUM_BANKS-1:0] bank_precharging,
  output logic input_buffers_on,
  output logic array_lost,
  output logic clock_stop_ok,
  output lpddr_ctl_pkg::power_state_t power_state
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  typedef struct packed {
    logic cke_meta;
    logic cke;
    lpddr_ctl_pkg::command_pins_t cmd_meta;
    lpddr_ctl_pkg::command_pins_t cmd;
    lpddr_ctl_pkg::write_beat_t beat_meta;
    lpddr_ctl_pkg::write_beat_t beat;
  } sync_t;

  typedef struct packed {
    lpddr_ctl_pkg::bank_state_t [`NUM_BANKS-1:0] bank;
    logic [`NUM_BANKS-1:0][7:0] bank_timer;
    logic [`NUM_BANKS-1:0] auto_pending;
    logic [7:0] burst_left;
    logic [1:0] burst_bank;
    logic burst_is_write;
    logic write_cut;
    lpddr_ctl_pkg::power_state_t pwr;
    logic [15:0] pwr_timer;
    logic [15:0] sr_timer;
    logic [12:0] refresh_row;
    logic refresh_strobe;
    lpddr_ctl_pkg::array_write_t array_write;
    logic array_lost;
    logic cke_prev;
  } state_t;

  sync_t sync_q;
  state_t state_q, state_d;
  lpddr_ctl_pkg::command_t cmd;
  logic [1:0] sel_bank;
  logic all_sel;
  logic all_idle;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_q <= '0;
    end else begin
      sync_q.cke_meta <= clock_enable;
      sync_q.cke <= sync_q.cke_meta;
      sync_q.cmd_meta <= cmd_pins;
      sync_q.cmd <= sync_q.cmd_meta;
      sync_q.beat_meta <= write_beat;
      sync_q.beat <= sync_q.beat_meta;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  always_comb begin
    cmd = lpddr_ctl_pkg::CMD_NOP;
    if (sync_q.cmd.chip_select_n) begin
      cmd = lpddr_ctl_pkg::CMD_DESELECT;
    end else begin
      case ({sync_q.cmd.row_strobe_n, sync_q.cmd.column_strobe_n, sync_q.cmd.write_enable_n})
        3'b011: cmd = lpddr_ctl_pkg::CMD_ACTIVE;
        3'b101: cmd = lpddr_ctl_pkg::CMD_READ;
        3'b100: cmd = lpddr_ctl_pkg::CMD_WRITE;
        3'b010: cmd = lpddr_ctl_pkg::CMD_PRECHARGE;
        3'b001: cmd = lpddr_ctl_pkg::CMD_REFRESH;
        3'b110: cmd = lpddr_ctl_pkg::CMD_BURST_TERMINATE;
        3'b000: cmd = lpddr_ctl_pkg::CMD_MODE_SET;
        default: cmd = lpddr_ctl_pkg::CMD_NOP;
      endcase
    end
  end

  assign sel_bank = sync_q.cmd.bank_select;
  assign all_sel = sync_q.cmd.address[`PRECHARGE_SELECT_POS];

  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < `NUM_BANKS; b++) begin
      if (state_q.bank[b] != lpddr_ctl_pkg::BANK_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.refresh_strobe = 1'b0;
    state_d.array_write = '0;
    state_d.cke_prev = sync_q.cke;

    for (int b = 0; b < `NUM_BANKS; b++) begin
      if (state_q.bank[b] == lpddr_ctl_pkg::BANK_PRECHARGING) begin
        if (state_q.bank_timer[b] <= 8'h01) begin
          state_d.bank[b] = lpddr_ctl_pkg::BANK_IDLE;
          state_d.bank_timer[b] = 8'h00;
        end else begin
          state_d.bank_timer[b] = state_q.bank_timer[b] - 8'h01;
        end
      end
    end

    // Burst progress and data capture
    if (state_q.burst_left != 8'h00) begin
      state_d.burst_left = state_q.burst_left - 8'h01;
      if (state_q.burst_is_write && !state_q.write_cut && sync_q.beat.data_valid &&
          !sync_q.beat.data_mask) begin
        state_d.array_write.array_write = 1'b1;
        state_d.array_write.bank = state_q.burst_bank;
        state_d.array_write.data = sync_q.beat.data;
      end
      if (state_q.burst_left == 8'h01 && state_q.auto_pending[state_q.burst_bank]) begin
        state_d.auto_pending[state_q.burst_bank] = 1'b0;
        state_d.bank[state_q.burst_bank] = lpddr_ctl_pkg::BANK_PRECHARGING;
        state_d.bank_timer[state_q.burst_bank] = 8'(`PRECHARGE_PERIOD_CYC);
      end
    end

    case (state_q.pwr)
      lpddr_ctl_pkg::PWR_NORMAL: begin
        if (!sync_q.cke && state_q.cke_prev) begin
          if (cmd == lpddr_ctl_pkg::CMD_REFRESH && all_idle) begin
            state_d.pwr = lpddr_ctl_pkg::PWR_SELF_REFRESH;
            state_d.pwr_timer = 16'(`REFRESH_CYCLE_CYC);
            state_d.sr_timer = 16'(`SELF_REFRESH_TIMER_CYC);
          end else if (cmd == lpddr_ctl_pkg::CMD_BURST_TERMINATE && all_idle &&
                       state_q.burst_left == 8'h00) begin
            state_d.pwr = lpddr_ctl_pkg::PWR_DEEP_DOWN;
            state_d.array_lost = 1'b1;
          end else if (state_q.burst_left == 8'h00) begin
            state_d.pwr = (bank_open != '0) ? lpddr_ctl_pkg::PWR_ACTIVE_DOWN :
                                              lpddr_ctl_pkg::PWR_PRECHARGE_DOWN;
          end
        end else if (sync_q.cke) begin
          case (cmd)
            lpddr_ctl_pkg::CMD_ACTIVE: begin
              if (state_q.bank[sel_bank] == lpddr_ctl_pkg::BANK_IDLE) begin
                state_d.bank[sel_bank] = lpddr_ctl_pkg::BANK_ACTIVE;
                state_d.array_lost = 1'b0;
              end
            end
            lpddr_ctl_pkg::CMD_READ, lpddr_ctl_pkg::CMD_WRITE: begin
              state_d.burst_left = 8'(`BURST_LEN / 2);
              state_d.burst_bank = sel_bank;
              state_d.burst_is_write = (cmd == lpddr_ctl_pkg::CMD_WRITE);
              state_d.write_cut = 1'b0;
              if (cmd == lpddr_ctl_pkg::CMD_READ && state_q.burst_is_write) begin
                state_d.write_cut = 1'b1;
              end
              state_d.auto_pending[sel_bank] = all_sel;
            end
            lpddr_ctl_pkg::CMD_PRECHARGE: begin
              for (int b = 0; b < `NUM_BANKS; b++) begin
                if ((all_sel || sel_bank == 2'(b)) &&
                    state_q.bank[b] == lpddr_ctl_pkg::BANK_ACTIVE) begin
                  state_d.bank[b] = lpddr_ctl_pkg::BANK_PRECHARGING;
                  state_d.bank_timer[b] = 8'(`PRECHARGE_PERIOD_CYC);
                  state_d.auto_pending[b] = 1'b0;
                  if (state_q.burst_is_write && state_q.burst_bank == 2'(b)) begin
                    state_d.write_cut = 1'b1;
                  end
                end
              end
            end
            lpddr_ctl_pkg::CMD_REFRESH: begin
              state_d.refresh_row = state_q.refresh_row + 13'h0001;
              state_d.refresh_strobe = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      lpddr_ctl_pkg::PWR_PRECHARGE_DOWN, lpddr_ctl_pkg::PWR_ACTIVE_DOWN: begin
        if (sync_q.cke && (cmd == lpddr_ctl_pkg::CMD_NOP ||
                           cmd == lpddr_ctl_pkg::CMD_DESELECT)) begin
          state_d.pwr = lpddr_ctl_pkg::PWR_EXIT;
          state_d.pwr_timer = 16'(`POWER_DOWN_EXIT_CYC);
        end
      end
      lpddr_ctl_pkg::PWR_SELF_REFRESH: begin
        if (state_q.pwr_timer != 16'h0000) begin
          state_d.pwr_timer = state_q.pwr_timer - 16'h0001;
        end
        if (state_q.sr_timer == 16'h0000) begin
          state_d.sr_timer = 16'(`SELF_REFRESH_TIMER_CYC);
          state_d.refresh_row = state_q.refresh_row + 13'h0001;
          state_d.refresh_strobe = 1'b1;
        end else begin
          state_d.sr_timer = state_q.sr_timer - 16'h0001;
        end
        if (sync_q.cke && state_q.pwr_timer == 16'h0000) begin
          state_d.pwr = lpddr_ctl_pkg::PWR_EXIT;
          state_d.pwr_timer = 16'(`SELF_REFRESH_EXIT_CYC);
        end
      end
      lpddr_ctl_pkg::PWR_DEEP_DOWN: begin
        if (sync_q.cke) begin
          state_d.pwr = lpddr_ctl_pkg::PWR_NORMAL;
          for (int b = 0; b < `NUM_BANKS; b++) begin
            state_d.bank[b] = lpddr_ctl_pkg::BANK_IDLE;
          end
        end
      end
      lpddr_ctl_pkg::PWR_EXIT: begin
        if (state_q.pwr_timer <= 16'h0001) begin
          state_d.pwr = lpddr_ctl_pkg::PWR_NORMAL;
          state_d.pwr_timer = 16'h0000;
        end else begin
          state_d.pwr_timer = state_q.pwr_timer - 16'h0001;
        end
      end
      default: begin
        state_d.pwr = lpddr_ctl_pkg::PWR_NORMAL;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign array_write = state_q.array_write;
  assign refresh_row = state_q.refresh_row;
  assign refresh_strobe = state_q.refresh_strobe;
  assign power_state = state_q.pwr;
  assign array_lost = state_q.array_lost;

  genvar g;
  generate
    for (g = 0; g < `NUM_BANKS; g++) begin : g_bank
      assign bank_open[g] = (state_q.bank[g] == lpddr_ctl_pkg::BANK_ACTIVE);
      assign bank_precharging[g] = (state_q.bank[g] == lpddr_ctl_pkg::BANK_PRECHARGING);
    end
  endgenerate

  assign input_buffers_on = (state_q.pwr == lpddr_ctl_pkg::PWR_NORMAL) ||
                            (state_q.pwr == lpddr_ctl_pkg::PWR_EXIT);
  assign clock_stop_ok = (state_q.pwr == lpddr_ctl_pkg::PWR_NORMAL) && sync_q.cke &&
                         (state_q.burst_left == 8'h00) && (bank_precharging == '0);

endmodule : lpddr_ctl

// file: testbench/ctl_model.sv
// Memory controller model driving command, clock enable and write data pins
module ctl_model (
  input wire logic mclk,
  output logic clock_enable,
  output lpddr_ctl_pkg::command_pins_t cmd_pins,
  output lpddr_ctl_pkg::write_beat_t write_beat
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    clock_enable = 1'h1;
    cmd_pins = {4'h8, 2'h0, 13'h0000};
    write_beat = '0;
  end
  // One cycle of pins; beat is valid then mask, idle data inverts
  task automatic step(input logic [3:0] code, input logic [1:0] bank, input logic [12:0] addr,
                      input logic cke, input logic [1:0] beat, input logic [15:0] data);
    clock_enable = cke;
    cmd_pins = {code, bank, addr};
    write_beat = {beat, beat[1] ? data : ~write_beat.data};
    @(posedge mclk);
    #1;
  endtask : step
  task automatic idle(input int n, input logic cke);
    for (int i = 0; i < n; i++) begin
      step(4'h7, ~cmd_pins.bank_select, ~cmd_pins.address, cke, 2'h0, 16'h0000);
    end
  endtask : idle
endmodule : ctl_model

// file: testbench/lpddr_ctl_monitor.sv
// Assertion checker for the precharge, refresh and power block
`include "lpddr_ctl_map.svh"
module lpddr_ctl_monitor (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clock_enable,
  input wire lpddr_ctl_pkg::command_pins_t cmd_pins,
  input wire lpddr_ctl_pkg::write_beat_t write_beat,
  input wire lpddr_ctl_pkg::array_write_t array_write,
  input wire logic [12:0] refresh_row,
  input wire logic refresh_strobe,
  input wire logic [`NUM_BANKS-1:0] bank_open,
  input wire logic [`NUM_BANKS-1:0] bank_precharging,
  input wire logic input_buffers_on,
  input wire logic array_lost,
  input wire logic clock_stop_ok,
  input wire lpddr_ctl_pkg::power_state_t power_state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic in_sr;
  logic low_pwr;
  logic [7:0] sr_len_q;
  logic [7:0] sr_len_d;
  assign in_sr = power_state == lpddr_ctl_pkg::PWR_SELF_REFRESH;
  assign low_pwr = power_state inside {lpddr_ctl_pkg::PWR_PRECHARGE_DOWN,
    lpddr_ctl_pkg::PWR_ACTIVE_DOWN, lpddr_ctl_pkg::PWR_SELF_REFRESH, lpddr_ctl_pkg::PWR_DEEP_DOWN};
  // ----------------------------------------
  // Self refresh stay counter
  // ----------------------------------------
  always_comb begin
    sr_len_d = in_sr ? sr_len_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) sr_len_q <= 8'h00;
    else sr_len_q <= sr_len_d;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_beat_kept;
    !$past(write_beat.data_mask, 3) && array_write.data == $past(write_beat.data, 3);
  endsequence
  for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_bank
    sequence s_prech_busy;
      bank_precharging[b] [*5];
    endsequence
    a_prech_period_held: assert property ($rose(bank_precharging[b]) |-> s_prech_busy ##1
      !bank_precharging[b]) else $error("precharge period length wrong");
  end
  a_bank_state_exclusive: assert property ((bank_open & bank_precharging) == '0)
    else $error("bank both open and precharging");
  a_buffers_gated_low: assert property (low_pwr && $past(low_pwr) |-> !input_buffers_on)
    else $error("input buffers on in low power");
  a_sr_min_stay: assert property ($past(in_sr) && !in_sr |-> sr_len_q >= `REFRESH_CYCLE_CYC - 1)
    else $error("self refresh left too early");
  a_sr_ignores_inputs: assert property (in_sr && !clock_enable && !$past(clock_enable) &&
    !$past(clock_enable, 2) |=> in_sr) else $error("self refresh left with clock enable low");
  a_write_beat_kept: assert property (array_write.array_write |-> s_beat_kept)
    else $error("array write does not match beat");
  a_mask_blocks_write: assert property (write_beat.data_mask |-> ##3 !array_write.array_write)
    else $error("masked beat written");
  a_stop_not_prech: assert property ($rose(|bank_precharging) |-> ##[0:1] !clock_stop_ok)
    else $error("clock stop allowed while precharging");
  a_deep_loses_data: assert property ($rose(power_state == lpddr_ctl_pkg::PWR_DEEP_DOWN)
    |-> ##[0:2] array_lost) else $error("deep power down without data loss");
  a_active_down_open: assert property (power_state == lpddr_ctl_pkg::PWR_ACTIVE_DOWN
    |-> bank_open != '0) else $error("active power down with no open bank");
  a_prech_down_idle: assert property (power_state == lpddr_ctl_pkg::PWR_PRECHARGE_DOWN
    |-> bank_open == '0) else $error("precharge power down with open bank");
  a_refresh_one_pulse: assert property (refresh_strobe |=> !refresh_strobe)
    else $error("refresh strobe longer than a cycle");
endmodule : lpddr_ctl_monitor

bind lpddr_ctl lpddr_ctl_monitor mon_u (.mclk(mclk), .resetn(resetn),
  .clock_enable(clock_enable), .cmd_pins(cmd_pins), .write_beat(write_beat),
  .array_write(array_write), .refresh_row(refresh_row), .refresh_strobe(refresh_strobe),
  .bank_open(bank_open), .bank_precharging(bank_precharging), .input_buffers_on(input_buffers_on),
  .array_lost(array_lost), .clock_stop_ok(clock_stop_ok), .power_state(power_state));

// file: testbench/tb.sv
// Self-checking bench for the precharge, refresh and power block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] ACT = 4'h3, RD = 4'h5, WR = 4'h4, PRE = 4'h2, REF = 4'h1, BST = 4'h6;
  typedef struct packed {
    logic [3:0] code;
    logic [1:0] bank;
    logic ap;
    logic [3:0] open;
    logic [3:0] prech;
  } row_t;
  logic mclk;
  logic resetn;
  logic clock_enable;
  lpddr_ctl_pkg::command_pins_t cmd_pins;
  lpddr_ctl_pkg::write_beat_t write_beat;
  lpddr_ctl_pkg::array_write_t array_write;
  lpddr_ctl_pkg::array_write_t last_aw;
  logic [12:0] refresh_row;
  logic [12:0] row_a;
  logic refresh_strobe;
  logic [3:0] bank_open;
  logic [3:0] bank_precharging;
  logic input_buffers_on;
  logic array_lost;
  logic clock_stop_ok;
  lpddr_ctl_pkg::power_state_t power_state;
  int num_errors;
  int checks_done;
  int writes_seen;
  int strobes_seen;
  row_t rows [8] = '{'{ACT, 2'h0, 1'h0, 4'h1, 4'h0}, '{ACT, 2'h2, 1'h0, 4'h5, 4'h0},
    '{PRE, 2'h0, 1'h0, 4'h4, 4'h1}, '{PRE, 2'h1, 1'h0, 4'h4, 4'h0},
    '{ACT, 2'h1, 1'h0, 4'h6, 4'h0}, '{PRE, 2'h0, 1'h1, 4'h0, 4'h6},
    '{ACT, 2'h0, 1'h0, 4'h1, 4'h0}, '{ACT, 2'h0, 1'h0, 4'h1, 4'h0}};
  lpddr_ctl dut_u (.mclk(mclk), .resetn(resetn), .clock_enable(clock_enable),
    .cmd_pins(cmd_pins), .write_beat(write_beat), .array_write(array_write),
    .refresh_row(refresh_row), .refresh_strobe(refresh_strobe), .bank_open(bank_open),
    .bank_precharging(bank_precharging), .input_buffers_on(input_buffers_on),
    .array_lost(array_lost), .clock_stop_ok(clock_stop_ok), .power_state(power_state));
  ctl_model ctl_u (.mclk(mclk), .clock_enable(clock_enable), .cmd_pins(cmd_pins),
    .write_beat(write_beat));
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (array_write.array_write === 1'h1) begin
      writes_seen++;
      last_aw = array_write;
    end
    if (refresh_strobe === 1'h1) strobes_seen++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task automatic wr_cut(input logic [3:0] cut, input logic [15:0] data);
    ctl_u.step(WR, 2'h0, 13'h0000, 1'h1, 2'h0, 16'h0000);
    ctl_u.step(4'h7, 2'h3, 13'h1fff, 1'h1, 2'h2, data);
    ctl_u.step(cut, 2'h0, 13'h0000, 1'h1, 2'h3, ~data);
    ctl_u.idle(10, 1'h1);
  endtask : wr_cut
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #300000;
    num_errors++;
    wrap_up();
  end
  initial begin
    resetn = 1'h0;
    repeat (6) @(posedge mclk);
    #1;
    chk({bank_open, bank_precharging, array_lost, clock_stop_ok, power_state}, 32'h0000_0000);
    resetn = 1'h1;
    ctl_u.idle(4, 1'h1);
    foreach (rows[i]) begin
      ctl_u.step(rows[i].code, rows[i].bank, {2'h0, rows[i].ap, 10'h000}, 1'h1, 2'h0, 16'h0000);
      ctl_u.idle(4, 1'h1);
      chk({bank_open, bank_precharging}, {rows[i].open, rows[i].prech});
      ctl_u.idle(6, 1'h1);
    end
    chk(clock_stop_ok, 1'h1);
    wr_cut(RD, 16'h1234);
    chk(writes_seen, 32'h0000_0001);
    chk({13'h0000, last_aw}, {13'h0000, 1'h1, 2'h0, 16'h1234});
    wr_cut(PRE, 16'ha5c3);
    chk(writes_seen, 32'h0000_0002);
    chk({13'h0000, last_aw}, {13'h0000, 1'h1, 2'h0, 16'ha5c3});
    chk(bank_open, 4'h0);
    for (int k = 0; k < 2; k++) begin
      ctl_u.step(ACT, 2'h3, 13'h0000, 1'h1, 2'h0, 16'h0000);
      ctl_u.idle(3, 1'h1);
      ctl_u.step(WR, 2'h3, {2'h0, ~k[0], 10'h000}, 1'h1, 2'h0, 16'h0000);
      ctl_u.step(4'h7, 2'h0, 13'h0000, 1'h1, 2'h2, 16'h0f0f);
      ctl_u.step(4'h7, 2'h0, 13'h0000, 1'h1, 2'h2, 16'hf0f0);
      for (int i = 0; i < 16 && bank_precharging[3] !== 1'h1; i++) ctl_u.idle(1, 1'h1);
      chk(clock_stop_ok, k[0]);
      ctl_u.idle(10, 1'h1);
      chk(bank_open, k ? 4'h8 : 4'h0);
    end
    ctl_u.step(PRE, 2'h0, 13'h0400, 1'h1, 2'h0, 16'h0000);
    ctl_u.idle(10, 1'h1);
    ctl_u.step(REF, 2'h0, 13'h0000, 1'h1, 2'h0, 16'h0000);
    ctl_u.idle(30, 1'h1);
    row_a = refresh_row;
    ctl_u.step(REF, 2'h0, 13'h0000, 1'h1, 2'h0, 16'h0000);
    ctl_u.idle(30, 1'h1);
    chk(strobes_seen, 32'h0000_0002);
    chk(refresh_row !== row_a, 1'h1);
    ctl_u.step(REF, 2'h0, 13'h0000, 1'h0, 2'h0, 16'h0000);
    ctl_u.idle(4, 1'h0);
    ctl_u.step(ACT, 2'h1, 13'h0000, 1'h0, 2'h0, 16'h0000);
    ctl_u.idle(40, 1'h0);
    chk({power_state, input_buffers_on, bank_open}, {3'h3, 1'h0, 4'h0});
    ctl_u.idle(36, 1'h1);
    chk(power_state, lpddr_ctl_pkg::PWR_NORMAL);
    ctl_u.step(REF, 2'h0, 13'h0000, 1'h1, 2'h0, 16'h0000);
    ctl_u.idle(30, 1'h1);
    for (int k = 0; k < 2; k++) begin
      ctl_u.step(k ? PRE : ACT, 2'h1, 13'h0400, 1'h1, 2'h0, 16'h0000);
      ctl_u.idle(10, 1'h1);
      ctl_u.idle(8, 1'h0);
      chk({power_state, input_buffers_on}, {k ? 3'h1 : 3'h2, 1'h0});
      ctl_u.idle(8, 1'h1);
      chk({power_state, input_buffers_on}, {3'h0, 1'h1});
    end
    ctl_u.step(BST, 2'h0, 13'h0000, 1'h0, 2'h0, 16'h0000);
    ctl_u.idle(10, 1'h0);
    chk({power_state, array_lost}, {3'h4, 1'h1});
    ctl_u.idle(50000, 1'h1);
    ctl_u.step(ACT, 2'h2, 13'h0000, 1'h1, 2'h0, 16'h0000);
    ctl_u.idle(6, 1'h1);
    chk({power_state, array_lost, bank_open}, {3'h0, 1'h0, 4'h4});
    wrap_up();
  end
endmodule : tb
